// [stm_cfg.svh]
/*
 * Register offsets, field positions, reset values and codes for the
 * standard timer register set.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

`define STM_OFS_CNT_LO   3'h0
`define STM_OFS_CNT_HI   3'h1
`define STM_OFS_CMPA_LO  3'h2
`define STM_OFS_CMPA_HI  3'h3
`define STM_OFS_CTRL0    3'h4
`define STM_OFS_CTRL1    3'h5
`define STM_OFS_CMPP     3'h6
`define STM_OFS_FLAGS    3'h7

`define STM_C0_PAUSE     7
`define STM_C0_CKS_HI    6
`define STM_C0_CKS_LO    4
`define STM_C0_ON        3
`define STM_C1_MODE_HI   7
`define STM_C1_MODE_LO   6
`define STM_C1_IO_HI     5
`define STM_C1_IO_LO     4
`define STM_C1_OC        3
`define STM_C1_POL       2
`define STM_C1_DPX       1
`define STM_C1_CCLR      0
`define STM_FLAG_A       0
`define STM_FLAG_P       1

`define STM_RST_BYTE     8'h00
`define STM_C0_RW_MASK   8'hF8

`define STM_DIV_HS16     16
`define STM_DIV_HS64     64
`define STM_DIV_SYS4     4

`endif

// [stm_pkg.sv]
/*
 * Types shared by the standard timer modules.
 * Assumes the constants header sits in the same folder.
 */
`include "stm_cfg.svh"

package stm_pkg;
    typedef logic [7:0]  stm_byte_t;
    typedef logic [15:0] stm_word_t;
    typedef logic [2:0]  stm_addr_t;

    typedef enum logic [1:0] {
        STM_MODE_CMP  = 2'h0,
        STM_MODE_UNDF = 2'h1,
        STM_MODE_PWM  = 2'h2,
        STM_MODE_TC   = 2'h3
    } stm_mode_e;

    typedef enum logic [2:0] {
        STM_CK_SYS4 = 3'h0,
        STM_CK_SYS  = 3'h1,
        STM_CK_H16  = 3'h2,
        STM_CK_H64  = 3'h3,
        STM_CK_SUB0 = 3'h4,
        STM_CK_SUB1 = 3'h5,
        STM_CK_EXTR = 3'h6,
        STM_CK_EXTF = 3'h7
    } stm_cksel_e;
endpackage : stm_pkg

// [stm_regif.sv]
/*
 * Register bus bundle between the timer top and its register file.
 * Assumes one clock domain; the top keeps the plain bus ports.
 */
`timescale 1ns/100ps
`default_nettype none

interface stm_regif;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] cmpp;
    logic [15:0] cmpa;
    logic [15:0] count;
    logic [1:0] flags;
    logic       on_clr;

    modport regs (input addr, wdata, wr, rd, count, flags, on_clr,
                  output rdata, ctrl0, ctrl1, cmpp, cmpa);
    modport core (output addr, wdata, wr, rd, count, flags, on_clr,
                  input rdata, ctrl0, ctrl1, cmpp, cmpa);
endinterface : stm_regif

`default_nettype wire

// [stm_regs.sv]
/*
 * Register file of the timer: control, compare and the shared low-byte
 * buffer, with registered read data.
 * Assumes a single clock, synchronous reset and a clock enable.
 */
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"

module stm_regs
    import stm_pkg::*;
(
    input  wire logic clk,    // System clock.
    input  wire logic rst,    // Synchronous reset, high.
    input  wire logic ce,     // Clock enable.
    stm_regif.regs    bus     // Bus and timer state.
);
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] cmpp_q;
    logic [7:0] cmpa_lo_q;
    logic [7:0] cmpa_hi_q;
    logic [7:0] buf_q;
    logic [7:0] rdata_q;

    assign bus.ctrl0 = ctrl0_q;
    assign bus.ctrl1 = ctrl1_q;
    assign bus.cmpp  = cmpp_q;
    assign bus.cmpa  = {cmpa_hi_q, cmpa_lo_q};
    assign bus.rdata = rdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl0_q <= `STM_RST_BYTE;
        end else if (ce) begin
            if (bus.wr && bus.addr == `STM_OFS_CTRL0) begin
                ctrl0_q <= bus.wdata & `STM_C0_RW_MASK;
            end else if (bus.on_clr) begin
                ctrl0_q[`STM_C0_ON] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q <= `STM_RST_BYTE;
            cmpp_q  <= `STM_RST_BYTE;
        end else if (ce && bus.wr) begin
            if (bus.addr == `STM_OFS_CTRL1) begin
                ctrl1_q <= bus.wdata;
            end
            if (bus.addr == `STM_OFS_CMPP) begin
                cmpp_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmpa_lo_q <= `STM_RST_BYTE;
            cmpa_hi_q <= `STM_RST_BYTE;
            buf_q     <= `STM_RST_BYTE;
        end else if (ce) begin
            if (bus.wr && bus.addr == `STM_OFS_CMPA_LO) begin
                buf_q <= bus.wdata;
            end else if (bus.wr && bus.addr == `STM_OFS_CMPA_HI) begin
                cmpa_hi_q <= bus.wdata;
                cmpa_lo_q <= buf_q;
            end else if (bus.rd && bus.addr == `STM_OFS_CMPA_HI) begin
                buf_q <= cmpa_lo_q;
            end else if (bus.rd && bus.addr == `STM_OFS_CNT_HI) begin
                buf_q <= bus.count[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `STM_RST_BYTE;
        end else if (ce) begin
            rdata_q <= `STM_RST_BYTE;
            if (bus.rd) begin
                case (bus.addr)
                    `STM_OFS_CNT_LO:  rdata_q <= buf_q;
                    `STM_OFS_CNT_HI:  rdata_q <= bus.count[15:8];
                    `STM_OFS_CMPA_LO: rdata_q <= buf_q;
                    `STM_OFS_CMPA_HI: rdata_q <= cmpa_hi_q;
                    `STM_OFS_CTRL0:   rdata_q <= ctrl0_q;
                    `STM_OFS_CTRL1:   rdata_q <= ctrl1_q;
                    `STM_OFS_CMPP:    rdata_q <= cmpp_q;
                    default:          rdata_q <= {6'h00, bus.flags};
                endcase
            end
        end
    end

    a_ctrl0_low_zero:
    assert property (@(posedge clk) disable iff (rst)
        ctrl0_q[2:0] == 3'h0)
        else $error("ctrl0 unused bits set");

    a_cmpa_hi_write:
    assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == `STM_OFS_CMPA_HI
        |=> cmpa_hi_q == $past(bus.wdata))
        else $error("compare A high byte not written");

    a_buf_latch:
    assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == `STM_OFS_CMPA_HI
        |=> cmpa_lo_q == $past(buf_q))
        else $error("low byte not taken from buffer");
endmodule : stm_regs

`default_nettype wire

// [stm_top.sv]
/*
 * Standard 16-bit timer: counter, clock select, comparators A and P and
 * the waveform output pin, with its register file.
 * Assumes the high-speed and subsidiary clocks and the count pin arrive
 * asynchronously and are synchronised here; they must run well below
 * half the system clock rate.
 */
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"

module stm_top
    import stm_pkg::*;
(
    input  wire logic       CLK_SYS,   // System clock, 40 MHz.
    input  wire logic       RST,       // Synchronous reset, high.
    input  wire logic       CE,        // Clock enable, freezes state.
    input  wire logic [2:0] ADDR,      // Register address.
    input  wire logic [7:0] WDATA,     // Write data.
    input  wire logic       WR,        // Write strobe.
    input  wire logic       RD,        // Read strobe.
    output logic      [7:0] RDATA,     // Read data, cycle after RD.
    input  wire logic       HS_CLK,    // High-speed clock, async.
    input  wire logic       SUB_CLK,   // Subsidiary clock, async.
    input  wire logic       CNT_IN,    // External count input pin.
    output logic            TOUT,      // Timer output pin level.
    output logic            TOUT_OE,   // Output pin drive enable.
    output logic            FLAG_A,    // Comparator A flag, sticky.
    output logic            FLAG_P     // Comparator P flag, sticky.
);
    stm_regif rif ();

    logic [2:0] hs_s_q;
    logic [2:0] sub_s_q;
    logic [2:0] ext_s_q;
    logic [5:0] hdiv_q;
    logic [1:0] sdiv_q;
    logic [15:0] cnt_q;
    logic        on_q;
    logic        out_q;
    logic [1:0]  flg_q;
    logic        tick;
    logic        hs_rise;
    logic        on_rise;
    logic        match_a;
    logic        match_p;
    logic        ovf;
    logic        clr;
    logic        pwm_act;

    logic        pause;
    logic        cnt_on;
    stm_cksel_e  cksel;
    stm_mode_e   mode;
    logic [1:0]  pfs;
    logic        oc;
    logic        pol;
    logic        dpx;
    logic        cclr;

    function automatic logic rise(input logic [2:0] s);
        rise = s[1] & ~s[2];
    endfunction : rise

    function automatic logic fall(input logic [2:0] s);
        fall = ~s[1] & s[2];
    endfunction : fall

    assign rif.addr  = ADDR;
    assign rif.wdata = WDATA;
    assign rif.wr    = WR;
    assign rif.rd    = RD;
    assign rif.count = cnt_q;
    assign rif.flags = flg_q;
    assign RDATA     = rif.rdata;

    stm_regs u_regs (
        .clk (CLK_SYS),
        .rst (RST),
        .ce  (CE),
        .bus (rif)
    );

    assign pause  = rif.ctrl0[`STM_C0_PAUSE];
    assign cnt_on = rif.ctrl0[`STM_C0_ON];
    assign cksel  = stm_cksel_e'(rif.ctrl0[`STM_C0_CKS_HI:`STM_C0_CKS_LO]);
    assign mode   = stm_mode_e'(rif.ctrl1[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);
    assign pfs    = rif.ctrl1[`STM_C1_IO_HI:`STM_C1_IO_LO];
    assign oc     = rif.ctrl1[`STM_C1_OC];
    assign pol    = rif.ctrl1[`STM_C1_POL];
    assign dpx    = rif.ctrl1[`STM_C1_DPX];
    assign cclr   = rif.ctrl1[`STM_C1_CCLR];

    // Two flops before any logic reads an async clock; third for edges.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hs_s_q  <= 3'h0;
            sub_s_q <= 3'h0;
            ext_s_q <= 3'h0;
        end else if (CE) begin
            hs_s_q  <= {hs_s_q[1:0], HS_CLK};
            sub_s_q <= {sub_s_q[1:0], SUB_CLK};
            ext_s_q <= {ext_s_q[1:0], CNT_IN};
        end
    end

    assign hs_rise = rise(hs_s_q);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hdiv_q <= 6'h00;
            sdiv_q <= 2'h0;
        end else if (CE) begin
            sdiv_q <= sdiv_q + 2'h1;
            if (hs_rise) begin
                hdiv_q <= hdiv_q + 6'h01;
            end
        end
    end

    always_comb begin
        case (cksel)
            STM_CK_SYS4: tick = (sdiv_q == 2'(`STM_DIV_SYS4 - 1));
            STM_CK_SYS:  tick = 1'b1;
            STM_CK_H16:  tick = hs_rise
                                && hdiv_q[3:0] == 4'(`STM_DIV_HS16 - 1);
            STM_CK_H64:  tick = hs_rise
                                && hdiv_q == 6'(`STM_DIV_HS64 - 1);
            STM_CK_SUB0: tick = rise(sub_s_q);
            STM_CK_SUB1: tick = rise(sub_s_q);
            STM_CK_EXTR: tick = rise(ext_s_q);
            STM_CK_EXTF: tick = fall(ext_s_q);
            default:     tick = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            on_q <= 1'b0;
        end else if (CE) begin
            on_q <= cnt_on;
        end
    end

    assign on_rise = cnt_on & ~on_q;

    // P compares the counter's top byte; zero means full wrap.
    assign match_p = tick && cnt_on && !pause
                     && cnt_q[15:8] == rif.cmpp - 8'h01
                     && cnt_q[7:0] == 8'hFF && rif.cmpp != 8'h00;
    assign match_a = tick && cnt_on && !pause && rif.cmpa != 16'h0000
                     && cnt_q + 16'h0001 == rif.cmpa;
    assign ovf     = tick && cnt_on && !pause && cnt_q == 16'hFFFF;

    // clear source; overflow only with P zero.
    // in PWM mode, except single pulse, the period register clears instead.
    always_comb begin
        if (mode == STM_MODE_PWM) begin
            clr = (pfs != 2'h3) && (dpx ? match_a : (match_p || ovf));
        end else if (cclr) begin
            clr = match_a;
        end else begin
            clr = match_p;
        end
    end

    // on rise clears. pause holds. off holds.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cnt_q <= 16'h0000;
        end else if (CE) begin
            if (on_rise) begin
                cnt_q <= 16'h0000;
            end else if (cnt_on && !pause && tick) begin
                cnt_q <= clr ? 16'h0000 : cnt_q + 16'h0001;
            end
        end
    end

    // Single pulse: an A match turns the counter off.
    assign rif.on_clr = CE && mode == STM_MODE_PWM && pfs == 2'h3
                        && match_a;

    // flags raised on matches; P flag absent when cclr makes A clear outside PWM mode.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            flg_q <= 2'h0;
        end else if (CE) begin
            if (WR && ADDR == `STM_OFS_FLAGS) begin
                flg_q <= flg_q & ~WDATA[1:0];
            end
            if (match_a) begin
                flg_q[`STM_FLAG_A] <= 1'b1;
            end
            if (match_p && !(cclr && mode != STM_MODE_PWM)) begin
                flg_q[`STM_FLAG_P] <= 1'b1;
            end
        end
    end

    // duty from the other register than the period.
    assign pwm_act = dpx ? (cnt_q < {rif.cmpp, 8'h00}
                            || rif.cmpp == 8'h00)
                         : (cnt_q < rif.cmpa);

    // on rise restores initial. compare action.
    // same level requested gives no change.
    // PWM pin behaviour. OC sets level or polarity.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            out_q <= 1'b0;
        end else if (CE) begin
            if (on_rise) begin
                out_q <= (mode == STM_MODE_PWM) ? (pfs == 2'h3 ? oc : ~oc)
                                                 : oc;
            end else if (mode == STM_MODE_CMP && match_a) begin
                case (pfs)
                    2'h1:    out_q <= 1'b0;
                    2'h2:    out_q <= 1'b1;
                    2'h3:    out_q <= ~out_q;
                    default: out_q <= out_q;
                endcase
            end else if (mode == STM_MODE_PWM) begin
                case (pfs)
                    2'h0:    out_q <= ~oc;
                    2'h1:    out_q <= oc;
                    2'h2:    out_q <= pwm_act ? oc : ~oc;
                    default: out_q <= cnt_on ? oc : ~oc;
                endcase
            end
        end
    end

    assign TOUT    = out_q ^ pol;
    // pin not driven in timer/counter or undefined mode.
    assign TOUT_OE = mode == STM_MODE_CMP || mode == STM_MODE_PWM;
    assign FLAG_A  = flg_q[`STM_FLAG_A];
    assign FLAG_P  = flg_q[`STM_FLAG_P];

    a_on_rise_clear:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && cnt_on && !on_q |=> cnt_q == 16'h0000)
        else $error("counter not cleared on enable");

    a_pause_hold:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && pause && on_q && cnt_on |=> $stable(cnt_q))
        else $error("counter moved while paused");

    a_off_hold:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && !cnt_on && !on_q |=> $stable(cnt_q))
        else $error("counter moved while off");

    a_init_level:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && on_rise && mode == STM_MODE_CMP |=> out_q == $past(oc))
        else $error("pin not at initial level");

    a_cmp_low:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && !on_rise && mode == STM_MODE_CMP && match_a && pfs == 2'h1
        |=> out_q == 1'b0)
        else $error("compare low action missed");

    a_invert_pin:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        TOUT == (out_q ^ pol))
        else $error("pin polarity wrong");

    a_cclr_a_clear:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && !on_rise && mode == STM_MODE_CMP && cclr && match_a
        |=> cnt_q == 16'h0000)
        else $error("A match did not clear");

    a_tc_no_drive:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        mode == STM_MODE_TC |-> !TOUT_OE)
        else $error("pin driven in timer mode");

    a_flag_p_set:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && match_p && !cclr && mode == STM_MODE_CMP
        |=> flg_q[`STM_FLAG_P])
        else $error("P flag not raised");

    a_cmp_high:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && !on_rise && mode == STM_MODE_CMP && match_a && pfs == 2'h2
        |=> out_q == 1'b1)
        else $error("compare high action missed");

    a_cmp_toggle:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && !on_rise && mode == STM_MODE_CMP && match_a && pfs == 2'h3
        |=> out_q != $past(out_q))
        else $error("compare toggle action missed");

    a_pulse_stop:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && mode == STM_MODE_PWM && pfs == 2'h3 && match_a
        && !(WR && ADDR == `STM_OFS_CTRL0) |=> !cnt_on)
        else $error("single pulse did not stop");

    a_p_flag_none:
    assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && cclr && mode == STM_MODE_CMP && !flg_q[`STM_FLAG_P]
        |=> !flg_q[`STM_FLAG_P])
        else $error("P flag raised with A clearing");
endmodule : stm_top

`default_nettype wire

// [stm_pin_model.sv]
/*
 * Far-side model of the timer pins: drives the count pin and measures
 * the output pin in system cycles and in edges of every clock source.
 * Assumes the slow clocks never share an edge with the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module stm_pin_model (
    input  wire logic clk,     // System clock.
    input  wire logic en,      // Let the count pin run.
    input  wire logic hs,      // High-speed clock.
    input  wire logic sub,     // Subsidiary clock.
    input  wire logic tout,    // Timer output pin.
    output logic      cnt_in,  // External count pin.
    output logic      chg,     // Output pin changed last cycle.
    output int        gap [5]  // Cycles, pin rises, pin falls, hs, sub.
);
    logic [2:0] ph_q = 3'h0;
    logic       p_q  = 1'b0;
    logic       h_q  = 1'b0;
    logic       s_q  = 1'b0;
    logic       t_q  = 1'b0;
    int         c_q [5] = '{0, 0, 0, 0, 0};

    initial cnt_in = 1'b0;

    // The count pin holds its level while the bench has it disabled.
    always @(posedge clk) begin
        logic [4:0] inc;
        inc = {!s_q && sub, !h_q && hs, p_q && !cnt_in, !p_q && cnt_in, 1'b1};
        ph_q <= ph_q + 3'h1;
        if (en && ph_q == 3'h7) cnt_in <= ~cnt_in;
        p_q <= cnt_in;
        h_q <= hs;
        s_q <= sub;
        t_q <= tout;
        chg <= (tout !== t_q);
        for (int i = 0; i < 5; i++) begin
            if (tout !== t_q) begin
                gap[i] <= c_q[i] + int'(inc[i]);
                c_q[i] <= 0;
            end else begin
                c_q[i] <= c_q[i] + int'(inc[i]);
            end
        end
    end
endmodule : stm_pin_model

`default_nettype wire

// [stm_top_bench.sv]
/*
 * Self-checking bench of the timer: register master, clocks and queues
 * of expected read data and expected output pin gaps.
 * Assumes the design and the pin model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "stm_cfg.svh"
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module stm_top_bench;
    import stm_pkg::*;
    typedef struct {int sel; bit fall; int val;} stm_gap_s;
    logic       clk, rst, ce, wr, rd, hs, sub, en, chg, rd_d, oc_v;
    logic       cnt, tout, oe, fa, fp;
    logic [1:0] io_v;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, lo, hi;
    int         gap [5];
    int         n_fail, samples_checked;
    int         seed = 32'hFF431342;
    int         sel_t [8] = '{0, 0, 3, 3, 4, 4, 1, 2};
    int         mul_t [8] = '{4, 1, 16, 64, 1, 1, 1, 1};
    logic [7:0] rd_q [$];
    stm_gap_s   gp_q [$];

    stm_top i_stm_top (.CLK_SYS(clk), .RST(rst), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HS_CLK(hs),
        .SUB_CLK(sub), .CNT_IN(cnt), .TOUT(tout), .TOUT_OE(oe),
        .FLAG_A(fa), .FLAG_P(fp));
    stm_pin_model i_stm_pin_model (.clk(clk), .en(en), .hs(hs), .sub(sub),
        .tout(tout), .cnt_in(cnt), .chg(chg), .gap(gap));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Odd offsets keep slow edges away from system clock edges.
    initial begin
        hs = 1'b0;
        #1.0;
        forever #35.0 hs = ~hs;
    end
    initial begin
        sub = 1'b0;
        #1.0;
        forever #155.0 sub = ~sub;
    end

    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d && rd_q.size() > 0) begin
            `CHK("rdata", rd_q[0], rdata)
            void'(rd_q.pop_front());
        end
        if (chg && gp_q.size() > 0 && (!gp_q[0].fall || tout === 1'b0)) begin
            `CHK("gap", gp_q[0].val, gap[gp_q[0].sel])
            void'(gp_q.pop_front());
        end
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask : wreg

    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        addr <= a;
        rd   <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
    endtask : rreg

    task automatic cmpa(input logic [15:0] v);
        wreg(`STM_OFS_CMPA_LO, v[7:0]);
        wreg(`STM_OFS_CMPA_HI, v[15:8]);
    endtask : cmpa

    task automatic start(input logic [7:0] c1, input logic [2:0] ck);
        wreg(`STM_OFS_CTRL0, 8'h00);
        wreg(`STM_OFS_CTRL1, c1);
        wreg(`STM_OFS_CTRL0, {1'b0, ck, 4'h8});
        // The pin takes its start level on the edge after the enable.
        repeat (2) @(posedge clk);
    endtask : start

    task automatic wait_chg(input int n);
        for (int i = 0; i < 20000 && n > 0; i++) begin
            @(posedge clk);
            if (chg) n--;
        end
        if (n > 0) begin
            n_fail++;
            print_verdict();
        end
        @(posedge clk);
    endtask : wait_chg

    task automatic drain();
        for (int i = 0; i < 20000 && gp_q.size() > 0; i++) @(posedge clk);
        if (gp_q.size() > 0) begin
            n_fail++;
            print_verdict();
        end
    endtask : drain

    task automatic expect_gap(input int sel, input bit fall, input int val);
        wait_chg(2);
        repeat (2) gp_q.push_back('{sel, fall, val});
        drain();
    endtask : expect_gap

    initial begin
        {rst, ce, wr, rd, en} = 5'b11000;
        addr = 3'h0;
        wdata = 8'h00;
        n_fail = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("oe", 1'b1, oe)
        for (int a = 0; a < 8; a++) rreg(3'(a), 8'h00);
        wreg(`STM_OFS_CTRL0, 8'hF7);
        rreg(`STM_OFS_CTRL0, 8'hF0);
        // Low byte moves only with the high byte.
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        cmpa({hi, lo});
        rreg(`STM_OFS_CMPA_HI, hi);
        rreg(`STM_OFS_CMPA_LO, lo);
        wreg(`STM_OFS_CMPA_LO, ~lo);
        rreg(`STM_OFS_CMPA_HI, hi);
        rreg(`STM_OFS_CMPA_LO, lo);
        wreg(`STM_OFS_CTRL1, lo);
        rreg(`STM_OFS_CTRL1, lo);
        cmpa(16'h0003);
        en <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            start(8'h31, 3'(c));
            expect_gap(sel_t[c], 1'b0, mul_t[c] * 3);
        end
        en <= 1'b0;
        // Pause, then a low clock enable, adds to one gap.
        cmpa(16'h0028);
        for (int k = 0; k < 2; k++) begin
            start(8'h31, 3'h1);
            wait_chg(2);
            gp_q.push_back('{0, 1'b0, 100});
            if (k == 0) begin
                wreg(`STM_OFS_CTRL0, 8'h98);
                repeat (58) @(posedge clk);
                wreg(`STM_OFS_CTRL0, 8'h18);
            end else begin
                ce <= 1'b0;
                repeat (60) @(posedge clk);
                ce <= 1'b1;
            end
            drain();
        end
        // Restart clears a counter past 512.
        cmpa(16'h0000);
        wreg(`STM_OFS_CMPP, 8'h00);
        start(8'h30, 3'h1);
        repeat (600) @(posedge clk);
        wreg(`STM_OFS_CTRL0, 8'h10);
        wreg(`STM_OFS_CTRL0, 8'h18);
        rreg(`STM_OFS_CNT_HI, 8'h00);
        cmpa(16'h0014);
        for (int i = 0; i < 4; i++) begin
            start({4'h3, 2'(i), 2'h1}, 3'h1);
            `CHK("tout", 1'(i / 2) ^ 1'(i), tout)
            repeat (25) @(posedge clk);
            `CHK("tout", ~(1'(i / 2) ^ 1'(i)), tout)
            start({4'h3, 2'(i), 2'h1}, 3'h1);
            `CHK("tout", 1'(i / 2) ^ 1'(i), tout)
        end
        // Match action against the initial level.
        for (int i = 0; i < 6; i++) begin
            io_v = 2'(i / 2);
            oc_v = 1'(i % 2);
            start({2'h0, io_v, oc_v, 3'h1}, 3'h1);
            repeat (70) @(posedge clk);
            `CHK("tout", (io_v == 2'h0) ? oc_v : io_v[1], tout)
        end
        for (int m = 0; m < 4; m++) begin
            start({2'(m), 6'h00}, 3'h1);
            `CHK("oe", ~1'(m), oe)
        end
        // P match period and both flags.
        wreg(`STM_OFS_CMPP, 8'h01);
        cmpa(16'h0080);
        start(8'h30, 3'h1);
        wreg(`STM_OFS_FLAGS, 8'h03);
        expect_gap(0, 1'b0, 256);
        `CHK("flag_p", 1'b1, fp)
        rreg(`STM_OFS_FLAGS, 8'h03);
        cmpa(16'h0200);
        start(8'h31, 3'h1);
        wreg(`STM_OFS_FLAGS, 8'h03);
        repeat (600) @(posedge clk);
        `CHK("flag_a", 1'b1, fa)
        rreg(`STM_OFS_FLAGS, 8'h01);
        cmpa(16'h0040);
        start(8'hA9, 3'h1);
        expect_gap(0, 1'b1, 64);
        cmpa(16'h0200);
        start(8'hAA, 3'h1);
        expect_gap(0, 1'b1, 256);
        for (int i = 0; i < 2; i++) begin
            start({3'h4, 1'(i), 4'h8}, 3'h1);
            `CHK("tout", 1'(i), tout)
        end
        // Single pulse ends on A match.
        cmpa(16'h0040);
        start(8'hB8, 3'h1);
        `CHK("tout", 1'b1, tout)
        repeat (100) @(posedge clk);
        `CHK("tout", 1'b0, tout)
        rreg(`STM_OFS_CTRL0, 8'h10);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule : stm_top_bench

`default_nettype wire
